/* tb/mdio_plc.sv */
// partner model: external controller driving the direct input terminals
`timescale 1ns/1ns
`default_nettype none
module mdio_plc #(
  parameter int HOLD_CYC = 12
) (
  // clock
  input wire logic clk,
  // direct terminals
  output var logic [5:0] pins
);
  // ---------------------------------------------------------------
  // level driver
  // ---------------------------------------------------------------
  initial pins = 6'h00;
  // hold every level
  // hold is far shorter than 10 ms to keep runs short, still past the synchroniser
  task automatic drive(input logic [5:0] v);
    @(posedge clk);
    #5;
    pins = v;
    repeat (HOLD_CYC) @(posedge clk);
    #10;
  endtask
endmodule
`default_nettype wire

/* tb/mdio_top_checker.sv */
// port-level assertions for the motor i/o signal layer
`timescale 1ns/1ns
`default_nettype none
module mdio_top_checker #(
  parameter int NUM_IN = 6,
  parameter int NUM_OUT = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // watched ports
  input wire logic [NUM_IN-1:0] input_pin,
  input wire logic [NUM_OUT-1:0] output_pin,
  input wire logic map_load,
  input wire logic [4*NUM_IN-1:0] in_map,
  input wire logic [4*NUM_OUT-1:0] out_map,
  input wire logic two_wire_mode,
  input wire mdio_pkg::mdio_stat_s motor_stat,
  input wire mdio_pkg::mdio_cmd_s motor_cmd,
  input wire logic alarm_active
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // default-map checks only; a custom map moves the functions elsewhere
  logic remap_ff, nxt_remap;
  logic [15:0] hi_ff, nxt_hi;
  always_comb begin
    nxt_remap = remap_ff;
    if (map_load) begin
      nxt_remap = (in_map != mdio_pkg::IN_MAP_RST) || (out_map != mdio_pkg::OUT_MAP_RST);
    end
    nxt_hi = output_pin[0] ? hi_ff + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      remap_ff <= 1'b0;
      hi_ff <= 16'h0000;
    end else begin
      remap_ff <= nxt_remap;
      hi_ff <= nxt_hi;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_alarm_nc_off: assert property ($rose(alarm_active) && !remap_ff |-> ##[0:3] !output_pin[1])
    else $error("alarm nc output stayed on");
  chk_alarm_stops: assert property (alarm_active [*3] |-> !motor_cmd.run)
    else $error("run kept during alarm");
  chk_pulse_start: assert property (motor_stat.rev_tick && !remap_ff |-> ##[1:3] output_pin[0])
    else $error("no rotation pulse after tick");
  chk_pulse_width: assert property ($fell(output_pin[0]) && !remap_ff |-> hi_ff == mdio_pkg::PULSE_CYCLES)
    else $error("rotation pulse width wrong");
  chk_trq_follow: assert property ($rose(motor_stat.trq_limited) && !remap_ff |-> ##[1:3] output_pin[2])
    else $error("torque limited output missing");
  chk_dir_hold: assert property ((!motor_stat.rotating && !remap_ff) [*5] |-> $stable(output_pin[3]))
    else $error("direction output moved while stopped");
  chk_run_go: assert property ((!two_wire_mode && !remap_ff && !alarm_active && !motor_stat.alarm
    && input_pin[1:0] == 2'b11) [*8] |-> motor_cmd.run) else $error("run not commanded");
  chk_permit_halt: assert property ((!two_wire_mode && !remap_ff && !input_pin[1]) [*8] |-> !motor_cmd.run)
    else $error("run kept without permit");
  chk_speed_bits: assert property ((!remap_ff && $stable(input_pin[4:3])) [*8]
    |-> motor_cmd.data_no[1:0] == input_pin[4:3]) else $error("data number mismatch");
  chk_clear_edge: assert property (alarm_active && !input_pin[5] ##1 (input_pin[5] && input_pin[1:0] == 2'b00
    && !motor_stat.alarm && !two_wire_mode && !remap_ff) [*8] |-> !alarm_active) else $error("alarm not cleared");
endmodule
bind mdio_top mdio_top_checker #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) chk (.clk(clk), .reset(reset),
  .input_pin(input_pin), .output_pin(output_pin), .map_load(map_load), .in_map(in_map), .out_map(out_map),
  .two_wire_mode(two_wire_mode), .motor_stat(motor_stat), .motor_cmd(motor_cmd), .alarm_active(alarm_active));
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the motor i/o signal layer
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, reset, map_load, two_wire_mode, alarm_active, notice_auto;
  logic [7:0] cause_v;
  logic [2:0] cause_bit;
  logic [23:0] in_map;
  logic [15:0] out_map;
  logic [5:0] pins, p;
  logic [3:0] output_pin;
  logic [7:0] notice_cause;
  mdio_pkg::mdio_stat_s motor_stat, st;
  mdio_pkg::mdio_cmd_s motor_cmd;
  int n_mismatch, checked, hi;
  // ---------------------------------------------------------------
  // clock, partner, design
  // ---------------------------------------------------------------
  initial clk = 1'b0;
  always #50 clk = ~clk;
  mdio_plc plc (.clk(clk), .pins(pins));
  mdio_top uut (.clk(clk), .reset(reset), .input_pin(pins), .output_pin(output_pin), .map_load(map_load),
    .in_map(in_map), .out_map(out_map), .two_wire_mode(two_wire_mode), .notice_auto_clear(notice_auto),
    .motor_stat(motor_stat), .motor_cmd(motor_cmd), .alarm_active(alarm_active), .notice_cause(notice_cause));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] exp_data(input logic [5:0] v);
    return {1'b0, v[4], v[3]};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic done(input string name);
    $display("test %s ended", name);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic stat(input mdio_pkg::mdio_stat_s s);
    @(posedge clk);
    #5;
    motor_stat = s;
    repeat (6) @(posedge clk);
    #10;
  endtask
  task automatic load(input logic [23:0] im, input logic [15:0] om, input logic tw);
    @(posedge clk);
    #5;
    in_map = im;
    out_map = om;
    two_wire_mode = tw;
    map_load = 1'b1;
    @(posedge clk);
    #5;
    map_load = 1'b0;
    repeat (6) @(posedge clk);
    #10;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    #2_000_000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    map_load = 1'b0;
    in_map = mdio_pkg::IN_MAP_RST;
    out_map = mdio_pkg::OUT_MAP_RST;
    two_wire_mode = 1'b0;
    notice_auto = 1'b1;
    motor_stat = '0;
    n_mismatch = 0;
    checked = 0;
    hi = $urandom(32'hD64F);
    repeat (12) @(posedge clk);
    #5;
    check(output_pin, 4'h0);
    check(motor_cmd.forward, 1'b1);
    reset = 1'b0;
    repeat (3) @(posedge clk);
    #10;
    check(output_pin[1], 1'b1);
    done("reset");
    for (int i = 0; i < 8; i++) begin
      p = {1'b0, 2'($urandom), 1'($urandom), 2'b11};
      plc.drive(p);
      check(motor_cmd.run, p[0] & p[1]);
      check(motor_cmd.forward, p[2]);
      check(motor_cmd.data_no, exp_data(p));
    end
    // core keeps turning so the stop state stands long enough to be seen
    st = '0;
    st.rotating = 1'b1;
    stat(st);
    plc.drive(6'h01);
    check(motor_cmd.run, 1'b0);
    check(motor_cmd.fast_stop, 1'b1);
    stat('0);
    plc.drive(6'h03);
    stat(st);
    plc.drive(6'h02);
    check(motor_cmd.run, 1'b0);
    check(motor_cmd.fast_stop, 1'b0);
    stat('0);
    done("three_wire");
    st = '0;
    st.alarm = 1'b1;
    stat(st);
    check(alarm_active, 1'b1);
    check(output_pin[1], 1'b0);
    check(motor_cmd.run, 1'b0);
    stat('0);
    plc.drive(6'h03);
    plc.drive(6'h23);
    check(alarm_active, 1'b1);
    plc.drive(6'h00);
    plc.drive(6'h20);
    check(alarm_active, 1'b0);
    check(output_pin[1], 1'b1);
    plc.drive(6'h00);
    done("alarm");
    st = '0;
    st.rev_tick = 1'b1;
    @(posedge clk);
    #5;
    motor_stat = st;
    @(posedge clk);
    #5;
    motor_stat = '0;
    hi = 0;
    repeat (2100) begin
      @(posedge clk);
      #10;
      hi += int'(output_pin[0]);
    end
    check(16'(hi), 16'(mdio_pkg::PULSE_CYCLES));
    done("pulse");
    st = '0;
    st.trq_limited = 1'b1;
    st.rotating = 1'b1;
    st.forward = 1'b1;
    stat(st);
    check(output_pin[2], 1'b1);
    check(output_pin[3], 1'b1);
    st.rotating = 1'b0;
    st.forward = 1'b0;
    stat(st);
    check(output_pin[3], 1'b1);
    st.rotating = 1'b1;
    st.trq_limited = 1'b0;
    stat(st);
    check(output_pin[3], 1'b0);
    check(output_pin[2], 1'b0);
    stat('0);
    done("status");
    load({mdio_pkg::IN_EXT_FAULT, mdio_pkg::IN_MAP_RST[19:0]},
      {mdio_pkg::OUT_ALM_NO, mdio_pkg::OUT_MAP_RST[11:0]}, 1'b0);
    check(alarm_active, 1'b1);
    check(output_pin[3], 1'b1);
    check(motor_cmd.trq_limit_en, 1'b1);
    load(mdio_pkg::IN_MAP_RST, mdio_pkg::OUT_MAP_RST, 1'b0);
    plc.drive(6'h20);
    check(alarm_active, 1'b0);
    plc.drive(6'h00);
    load({mdio_pkg::IN_TRQ_EN, mdio_pkg::IN_SPD1, mdio_pkg::IN_SPD0, mdio_pkg::IN_STOP_STYLE,
      mdio_pkg::IN_BWD, mdio_pkg::IN_FWD}, mdio_pkg::OUT_MAP_RST, 1'b1);
    check(motor_cmd.trq_limit_en, 1'b0);
    plc.drive(6'h01);
    check(motor_cmd.run, 1'b1);
    check(motor_cmd.forward, 1'b1);
    st = '0;
    st.rotating = 1'b1;
    stat(st);
    plc.drive(6'h00);
    check(motor_cmd.run, 1'b0);
    check(motor_cmd.fast_stop, 1'b0);
    plc.drive(6'h02);
    check(motor_cmd.run, 1'b1);
    check(motor_cmd.forward, 1'b0);
    plc.drive(6'h04);
    check(motor_cmd.run, 1'b0);
    check(motor_cmd.fast_stop, 1'b1);
    stat('0);
    plc.drive(6'h00);
    load(mdio_pkg::IN_MAP_RST, mdio_pkg::OUT_MAP_RST, 1'b0);
    done("remap");
    @(posedge clk);
    #5;
    notice_auto = 1'b0;
    cause_v = 8'($urandom) | 8'h01;
    cause_bit = 3'($urandom);
    load({mdio_pkg::IN_TOOL_UNLOCK, mdio_pkg::IN_NOTE_CLR, mdio_pkg::IN_SPD2, mdio_pkg::IN_SPD1, mdio_pkg::IN_SPD0,
      mdio_pkg::IN_NONE}, {mdio_pkg::OUT_NOTICE, mdio_pkg::OUT_SPD_OK, mdio_pkg::OUT_MOTION,
      mdio_pkg::OUT_CAUSE0 | {1'b0, cause_bit}}, 1'b0);
    st = '0;
    st.cause = cause_v;
    st.speed_ok = 1'b1;
    st.rotating = 1'b1;
    stat(st);
    check(notice_cause, cause_v);
    check(output_pin[0], cause_v[cause_bit]);
    check(output_pin[1], 1'b1);
    check(output_pin[2], 1'b1);
    p = {1'b1, 1'b0, 3'($urandom), 1'b0};
    plc.drive(p);
    check(motor_cmd.data_no, p[3:1]);
    check(motor_cmd.tool_unlock, 1'b1);
    stat('0);
    check(notice_cause, cause_v);
    check(output_pin[3], 1'b1);
    check(output_pin[1], 1'b0);
    check(output_pin[2], 1'b0);
    plc.drive(6'h10);
    check(notice_cause, 8'h00);
    check(output_pin[3], 1'b0);
    check(motor_cmd.tool_unlock, 1'b0);
    plc.drive(6'h00);
    @(posedge clk);
    #5;
    notice_auto = 1'b1;
    stat(st);
    check(notice_cause, cause_v);
    stat('0);
    check(notice_cause, 8'h00);
    load(mdio_pkg::IN_MAP_RST, mdio_pkg::OUT_MAP_RST, 1'b0);
    done("notice");
    print_verdict();
  end
endmodule
`default_nettype wire

/* verilog/mdio_pkg.sv */
// package: constants, function codes and carrier structs for the motor i/o signal layer
package mdio_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int PULSE_WIDTH_NS = 200000;
  localparam int PULSE_CYCLES = (PULSE_WIDTH_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int PULSES_PER_REV = 30;
  localparam int NUM_IN = 6;
  localparam int NUM_OUT = 4;
  localparam int SYNC_STAGES = 3;
  // ---------------------------------------------------------------
  // input function codes
  // ---------------------------------------------------------------
  localparam logic [3:0] IN_NONE = 4'h0;
  localparam logic [3:0] IN_RUN_REQ = 4'h1;
  localparam logic [3:0] IN_RUN_PERMIT = 4'h2;
  localparam logic [3:0] IN_DIR_SEL = 4'h3;
  localparam logic [3:0] IN_SPD0 = 4'h4;
  localparam logic [3:0] IN_SPD1 = 4'h5;
  localparam logic [3:0] IN_ALM_CLR = 4'h6;
  localparam logic [3:0] IN_FWD = 4'h7;
  localparam logic [3:0] IN_BWD = 4'h8;
  localparam logic [3:0] IN_STOP_STYLE = 4'h9;
  localparam logic [3:0] IN_SPD2 = 4'hA;
  localparam logic [3:0] IN_TRQ_EN = 4'hB;
  localparam logic [3:0] IN_NOTE_CLR = 4'hC;
  localparam logic [3:0] IN_TOOL_UNLOCK = 4'hD;
  localparam logic [3:0] IN_EXT_FAULT = 4'hE;
  // ---------------------------------------------------------------
  // output function codes
  // ---------------------------------------------------------------
  localparam logic [3:0] OUT_PULSE = 4'h0;
  localparam logic [3:0] OUT_ALM_NC = 4'h1;
  localparam logic [3:0] OUT_TRQ_LIM = 4'h2;
  localparam logic [3:0] OUT_DIR = 4'h3;
  localparam logic [3:0] OUT_ALM_NO = 4'h4;
  localparam logic [3:0] OUT_MOTION = 4'h5;
  localparam logic [3:0] OUT_NOTICE = 4'h6;
  localparam logic [3:0] OUT_SPD_OK = 4'h7;
  localparam logic [3:0] OUT_CAUSE0 = 4'h8;
  localparam int NUM_CAUSE = 8;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [23:0] IN_MAP_RST = {IN_ALM_CLR, IN_SPD1, IN_SPD0, IN_DIR_SEL, IN_RUN_PERMIT, IN_RUN_REQ};
  localparam logic [15:0] OUT_MAP_RST = {OUT_DIR, OUT_TRQ_LIM, OUT_ALM_NC, OUT_PULSE};
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MDIO_STOPPED = 2'b00,
    MDIO_RUNNING = 2'b01,
    MDIO_DECEL = 2'b11,
    MDIO_HALT = 2'b10
  } mdio_run_e;
  typedef struct packed {
    logic run;
    logic forward;
    logic fast_stop;
    logic [2:0] data_no;
    logic trq_limit_en;
    logic tool_unlock;
    logic alarm_clear;
    logic notice_clear;
  } mdio_cmd_s;
  typedef struct packed {
    logic rotating;
    logic forward;
    logic rev_tick;
    logic trq_limited;
    logic speed_ok;
    logic alarm;
    logic [7:0] cause;
  } mdio_stat_s;
endpackage

/* verilog/mdio_sync.sv */
// three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/1ns
`default_nettype none
module mdio_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pin and clean level
  input wire logic pin,
  output logic level
);
  logic [2:0] sh_ff;
  logic [2:0] nxt_sh;
  logic lvl_ff;
  logic nxt_lvl;

  always_comb begin
    nxt_sh = {sh_ff[1:0], pin};
    nxt_lvl = (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : lvl_ff;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sh_ff <= 3'h0;
      lvl_ff <= 1'b0;
    end else begin
      sh_ff <= nxt_sh;
      lvl_ff <= nxt_lvl;
    end
  end

  assign level = lvl_ff;
endmodule
`default_nettype wire

/* verilog/mdio_top.sv */
// motor driver digital i/o signal layer: input decode, run control and output mapping
`timescale 1ns/1ns
`default_nettype none
module mdio_top #(
  parameter int NUM_IN = mdio_pkg::NUM_IN,
  parameter int NUM_OUT = mdio_pkg::NUM_OUT,
  parameter int PULSES_PER_REV = mdio_pkg::PULSES_PER_REV
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // direct terminals
  input wire logic [NUM_IN-1:0] input_pin,
  output logic [NUM_OUT-1:0] output_pin,
  // function selection parameters
  input wire logic map_load,
  input wire logic [4*NUM_IN-1:0] in_map,
  input wire logic [4*NUM_OUT-1:0] out_map,
  input wire logic two_wire_mode,
  input wire logic notice_auto_clear,
  // motor core status
  input wire mdio_pkg::mdio_stat_s motor_stat,
  // motor core commands
  output mdio_pkg::mdio_cmd_s motor_cmd,
  output logic alarm_active,
  output logic [7:0] notice_cause
);
  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [NUM_IN-1:0] pin_lvl;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_sync
      mdio_sync u_sync (
        .clk(clk),
        .reset(reset),
        .pin(input_pin[gi]),
        .level(pin_lvl[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // function map registers
  // ---------------------------------------------------------------
  logic [4*NUM_IN-1:0] in_map_ff;
  logic [4*NUM_IN-1:0] nxt_in_map;
  logic [4*NUM_OUT-1:0] out_map_ff;
  logic [4*NUM_OUT-1:0] nxt_out_map;

  always_comb begin
    nxt_in_map = map_load ? in_map : in_map_ff;
    nxt_out_map = map_load ? out_map : out_map_ff;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in_map_ff <= mdio_pkg::IN_MAP_RST[4*NUM_IN-1:0];
      out_map_ff <= mdio_pkg::OUT_MAP_RST[4*NUM_OUT-1:0];
    end else begin
      in_map_ff <= nxt_in_map;
      out_map_ff <= nxt_out_map;
    end
  end

  // ---------------------------------------------------------------
  // function decode
  // ---------------------------------------------------------------
  // one bit per function code; a function on several terminals needs all of them on
  logic [15:0] fn_on;
  logic [15:0] fn_seen;
  always_comb begin
    fn_on = 16'hFFFF;
    fn_seen = 16'h0000;
    for (int i = 0; i < NUM_IN; i++) begin
      fn_seen[in_map_ff[4*i +: 4]] = 1'b1;
      fn_on[in_map_ff[4*i +: 4]] = fn_on[in_map_ff[4*i +: 4]] & pin_lvl[i];
    end
  end

  logic run_req, run_permit, dir_sel, fwd_in, bwd_in, stop_style;
  logic alm_clr_in, note_clr_in, trq_en, tool_unlock, ext_ok;
  logic [2:0] data_no;
  always_comb begin
    run_req = fn_seen[mdio_pkg::IN_RUN_REQ] & fn_on[mdio_pkg::IN_RUN_REQ];
    run_permit = fn_seen[mdio_pkg::IN_RUN_PERMIT] & fn_on[mdio_pkg::IN_RUN_PERMIT];
    dir_sel = fn_seen[mdio_pkg::IN_DIR_SEL] & fn_on[mdio_pkg::IN_DIR_SEL];
    fwd_in = fn_seen[mdio_pkg::IN_FWD] & fn_on[mdio_pkg::IN_FWD];
    bwd_in = fn_seen[mdio_pkg::IN_BWD] & fn_on[mdio_pkg::IN_BWD];
    stop_style = fn_seen[mdio_pkg::IN_STOP_STYLE] & fn_on[mdio_pkg::IN_STOP_STYLE];
    alm_clr_in = fn_seen[mdio_pkg::IN_ALM_CLR] & fn_on[mdio_pkg::IN_ALM_CLR];
    note_clr_in = fn_seen[mdio_pkg::IN_NOTE_CLR] & fn_on[mdio_pkg::IN_NOTE_CLR];
    data_no[0] = fn_seen[mdio_pkg::IN_SPD0] & fn_on[mdio_pkg::IN_SPD0];
    data_no[1] = fn_seen[mdio_pkg::IN_SPD1] & fn_on[mdio_pkg::IN_SPD1];
    data_no[2] = fn_seen[mdio_pkg::IN_SPD2] & fn_on[mdio_pkg::IN_SPD2];
    trq_en = fn_on[mdio_pkg::IN_TRQ_EN];
    tool_unlock = fn_on[mdio_pkg::IN_TOOL_UNLOCK];
    ext_ok = fn_on[mdio_pkg::IN_EXT_FAULT];
  end

  // ---------------------------------------------------------------
  // operation command state
  // ---------------------------------------------------------------
  mdio_pkg::mdio_run_e run_ff;
  mdio_pkg::mdio_run_e nxt_run;
  logic fwd_ff, nxt_fwd;
  logic alm_ff, nxt_alm;
  logic alm_clr_d_ff, note_clr_d_ff;
  logic [7:0] note_ff, nxt_note;
  logic go, want_fwd, fast, clr_block;

  always_comb begin
    if (two_wire_mode) begin
      go = fwd_in ^ bwd_in;
      want_fwd = fwd_in;
      fast = stop_style & ~(fwd_in & bwd_in);
      // either run input on blocks alarm clear
      clr_block = fwd_in | bwd_in;
    end else begin
      go = run_req & run_permit;
      want_fwd = dir_sel;
      fast = ~run_permit;
      clr_block = go;
    end
  end

  always_comb begin
    nxt_run = run_ff;
    nxt_fwd = fwd_ff;
    nxt_alm = alm_ff;
    // clear alarm
    // clear refused while run is commanded, so a live motor never restarts by surprise
    if (alm_clr_in & ~alm_clr_d_ff & ~clr_block) begin
      nxt_alm = 1'b0;
    end
    if (~ext_ok | motor_stat.alarm) begin
      nxt_alm = 1'b1;
    end
    if (nxt_alm) begin
      nxt_run = mdio_pkg::MDIO_HALT;
    end else begin
      unique case (run_ff)
        mdio_pkg::MDIO_STOPPED: begin
          if (go) begin
            nxt_run = mdio_pkg::MDIO_RUNNING;
            nxt_fwd = want_fwd;
          end
        end
        mdio_pkg::MDIO_RUNNING: begin
          if (!go) begin
            nxt_run = fast ? mdio_pkg::MDIO_HALT : mdio_pkg::MDIO_DECEL;
          end else begin
            nxt_fwd = want_fwd;
          end
        end
        mdio_pkg::MDIO_DECEL: begin
          if (go) begin
            nxt_run = mdio_pkg::MDIO_RUNNING;
          end else if (fast) begin
            nxt_run = mdio_pkg::MDIO_HALT;
          end else if (!motor_stat.rotating) begin
            nxt_run = mdio_pkg::MDIO_STOPPED;
          end
        end
        mdio_pkg::MDIO_HALT: begin
          if (!motor_stat.rotating) begin
            nxt_run = mdio_pkg::MDIO_STOPPED;
          end
        end
      endcase
    end
  end

  always_comb begin
    if (notice_auto_clear) begin
      nxt_note = motor_stat.cause;
    end else begin
      nxt_note = (note_clr_in & ~note_clr_d_ff) ? 8'h00 : note_ff;
      nxt_note = nxt_note | motor_stat.cause;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_ff <= mdio_pkg::MDIO_STOPPED;
      fwd_ff <= 1'b1;
      alm_ff <= 1'b0;
      alm_clr_d_ff <= 1'b0;
      note_clr_d_ff <= 1'b0;
      note_ff <= 8'h00;
    end else begin
      run_ff <= nxt_run;
      fwd_ff <= nxt_fwd;
      alm_ff <= nxt_alm;
      alm_clr_d_ff <= alm_clr_in;
      note_clr_d_ff <= note_clr_in;
      note_ff <= nxt_note;
    end
  end

  // ---------------------------------------------------------------
  // rotation pulse and direction output
  // ---------------------------------------------------------------
  logic [15:0] pw_ff, nxt_pw;
  logic dir_ff, nxt_dir;
  // 0.2 ms width
  // core ticks PULSES_PER_REV times a turn; a tick inside a pulse restarts it
  always_comb begin
    nxt_pw = (pw_ff != 16'h0000) ? pw_ff - 16'h0001 : 16'h0000;
    if (motor_stat.rev_tick) begin
      nxt_pw = 16'(mdio_pkg::PULSE_CYCLES);
    end
    nxt_dir = dir_ff;
    if (motor_stat.rotating) begin
      nxt_dir = motor_stat.forward;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pw_ff <= 16'h0000;
      dir_ff <= 1'b0;
    end else begin
      pw_ff <= nxt_pw;
      dir_ff <= nxt_dir;
    end
  end

  // ---------------------------------------------------------------
  // output mapping
  // ---------------------------------------------------------------
  logic [15:0] out_fn;
  logic [NUM_OUT-1:0] nxt_out;
  logic [NUM_OUT-1:0] out_ff;
  always_comb begin
    out_fn = 16'h0000;
    out_fn[mdio_pkg::OUT_PULSE] = (pw_ff != 16'h0000);
    out_fn[mdio_pkg::OUT_ALM_NC] = ~alm_ff;
    out_fn[mdio_pkg::OUT_ALM_NO] = alm_ff;
    out_fn[mdio_pkg::OUT_TRQ_LIM] = motor_stat.trq_limited;
    out_fn[mdio_pkg::OUT_DIR] = dir_ff;
    out_fn[mdio_pkg::OUT_MOTION] = motor_stat.rotating;
    out_fn[mdio_pkg::OUT_NOTICE] = |note_ff;
    out_fn[mdio_pkg::OUT_SPD_OK] = motor_stat.speed_ok;
    out_fn[15:8] = note_ff;
    for (int k = 0; k < NUM_OUT; k++) begin
      nxt_out[k] = out_fn[out_map_ff[4*k +: 4]];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_ff <= '0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  // ---------------------------------------------------------------
  // motor core command
  // ---------------------------------------------------------------
  always_comb begin
    motor_cmd.run = (run_ff == mdio_pkg::MDIO_RUNNING);
    motor_cmd.forward = fwd_ff;
    motor_cmd.fast_stop = (run_ff == mdio_pkg::MDIO_HALT);
    motor_cmd.data_no = data_no;
    motor_cmd.trq_limit_en = trq_en;
    motor_cmd.tool_unlock = tool_unlock;
    motor_cmd.alarm_clear = alm_ff & ~nxt_alm;
    motor_cmd.notice_clear = note_clr_in & ~note_clr_d_ff;
  end

  assign output_pin = out_ff;
  assign alarm_active = alm_ff;
  assign notice_cause = note_ff;
endmodule
`default_nettype wire
